// *** cmd_ecc_pkg.sv ***
// shared constants for the command file and ecc data path
package cmd_ecc_pkg;
    localparam int PTR_W = 2;
    localparam int DATA_W = 64;
    localparam int CHK_W = 8;
    localparam int NEED_W = 3;
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PASS_DELAY_NS = 15;
    // least time rounds up, never below one cycle
    localparam int PASS_DELAY_CYC =
        ((PASS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((PASS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] TAG_GOOD = 2'h0;
    localparam logic [1:0] TAG_CORRECTED = 2'h1;
    localparam logic [1:0] TAG_SUBSTITUTE = 2'h2;
    localparam logic [3:0] FULL_MASK = 4'hF;
    typedef enum logic [1:0] {T0, T1, T2, T3} time_state_t;
    typedef enum logic [2:0] {
        IDLE, CHECK_READ, MERGE, GEN_WRITE, ARRAY_WRITE
    } cycle_state_t;
endpackage

// *** secded_code.sv ***
// hamming plus overall parity encoder and checker, 64 data + 8 check bits
`timescale 1ns/100ps
module secded_code (
    input wire logic [63:0] data,
    input wire logic [7:0] check_in,
    output logic [7:0] check_gen,
    output logic [7:0] syndrome_bits,
    output logic single_err,
    output logic double_err,
    output logic [63:0] flip
);
    // data bit i sits at codeword position pos(i), skipping powers of two
    function automatic logic [6:0] pos(input int i);
        int p;
        int k;
        p = 0;
        k = -1;
        for (int n = 1; n < 128; n++) begin
            if ((n & (n - 1)) != 0 && k < i) begin
                k++;
                p = n;
            end
        end
        return 7'(p);
    endfunction

    always_comb begin
        check_gen = '0;
        for (int i = 0; i < 64; i++) begin
            for (int b = 0; b < 7; b++) begin
                if (pos(i)[b]) begin
                    check_gen[b] = check_gen[b] ^ data[i];
                end
            end
        end
        check_gen[7] = ^{data, check_gen[6:0]};
    end

    // overall bit is checked against the stored bits, not the regenerated ones,
    // so a data upset always flips it exactly once
    assign syndrome_bits = {^{data, check_in}, check_gen[6:0] ^ check_in[6:0]};
    // overall parity bit 7 flags odd weight: one bit; even weight nonzero: two
    assign single_err = syndrome_bits[7];
    assign double_err = !syndrome_bits[7] && (syndrome_bits[6:0] != 7'h00);

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_flip
            assign flip[g] = single_err && (syndrome_bits[6:0] == pos(g));
        end
    endgenerate
endmodule

// *** command_file_ecc_datapath.sv ***
// command file pointer control and ecc read / merge / write data path
`timescale 1ns/100ps
// Behaviour
// - two-bit write and read pointers
// - write advance at T0 on valid, room
// - read advance at T1, not empty, idle
// - empty file bypass advance, delayed one cycle (15 ns rounded up)
// - full flag set at T3 one behind
// - full blocks writes, cleared on read
// - init clears both pointers
// - free space from write minus read
// - full flag resolves zero difference
// - room check else busy confirmation
// - reads latch, check, correct, return data
// - correctable read error triggers rewrite
// - partial writes read and check first
// - merge bytes, regenerate check, write
// - uncorrectable write: rewrite original unchanged
// - full write skips check read
// - select longword half onto file bus
// - separate latches, diagnostic check mux
// - eight-bit syndrome to detect logic
// - tag good, corrected or substitute
// - byte mask enables write latches
// - correct single, leave double errors
// - parity per longword, matching half
module command_file_ecc_datapath (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic init_clear_n,
    input wire logic valid_format_decoded,
    input wire logic [2:0] entries_needed,
    output logic room_available,
    output logic busy_confirm,
    output logic [1:0] write_pointer,
    output logic [1:0] read_pointer,
    output logic file_full_flag,
    output logic file_not_empty,
    output logic read_pointer_advance,
    output logic write_pointer_advance,
    input wire logic cycle_start,
    input wire logic cycle_is_read,
    input wire logic cycle_ext,
    input wire logic [7:0] byte_mask,
    input wire logic [63:0] new_data,
    input wire logic read_mux_enable_n,
    input wire logic low_half_select_n,
    input wire logic diag_check_select,
    input wire logic [7:0] diag_check_bits,
    input wire logic array_data_latch_strobe,
    input wire logic check_bit_latch_strobe,
    input wire logic [63:0] array_data_in,
    input wire logic [7:0] array_check_in,
    input wire logic array_done,
    output logic array_read_req,
    output logic array_write_req,
    output logic [63:0] array_data_out,
    output logic [7:0] array_check_out,
    output logic memory_busy_flag,
    output logic [31:0] file_data_out,
    output logic file_data_valid,
    output logic file_parity,
    output logic [1:0] read_tag,
    output logic [7:0] syndrome_bits,
    output logic correction_enable
);
    // ==========================================
    // time states
    cmd_ecc_pkg::time_state_t tstate;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tstate <= cmd_ecc_pkg::T0;
        end else if (clk_en) begin
            unique case (tstate)
                cmd_ecc_pkg::T0: tstate <= cmd_ecc_pkg::T1;
                cmd_ecc_pkg::T1: tstate <= cmd_ecc_pkg::T2;
                cmd_ecc_pkg::T2: tstate <= cmd_ecc_pkg::T3;
                cmd_ecc_pkg::T3: tstate <= cmd_ecc_pkg::T0;
            endcase
        end
    end

    // init strobe is a pin: two flip-flops first
    logic init_s1;
    logic init_s2;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_s1 <= 1'b0;
            init_s2 <= 1'b0;
        end else if (clk_en) begin
            init_s1 <= !init_clear_n;
            init_s2 <= init_s1;
        end
    end

    // ==========================================
    // file control
    logic [1:0] diff;
    logic [2:0] free_entries;
    logic pointer_one_behind;
    logic bypass_pending;
    logic [1:0] bypass_cnt;
    assign diff = write_pointer - read_pointer;
    // zero difference means full only with the flag set
    assign free_entries = file_full_flag ? 3'h0 : 3'(3'h4 - {1'b0, diff});
    assign room_available = !file_full_flag && (free_entries >= entries_needed);
    assign busy_confirm = valid_format_decoded && !room_available;
    assign file_not_empty = (diff != 2'h0) || file_full_flag;
    assign pointer_one_behind = (2'(write_pointer + 2'h1) == read_pointer);
    assign write_pointer_advance = clk_en && tstate == cmd_ecc_pkg::T0 &&
        valid_format_decoded && room_available;
    assign read_pointer_advance = clk_en && !init_s2 && (
        (tstate == cmd_ecc_pkg::T1 && file_not_empty && !memory_busy_flag) ||
        (bypass_pending && bypass_cnt == 2'(cmd_ecc_pkg::PASS_DELAY_CYC - 1)));

    // bypass: empty file, format written at T0, read taken after the pass delay
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bypass_pending <= 1'b0;
            bypass_cnt <= 2'h0;
        end else if (clk_en) begin
            if (write_pointer_advance && !file_not_empty && !memory_busy_flag) begin
                bypass_pending <= 1'b1;
                bypass_cnt <= 2'h0;
            end else if (read_pointer_advance) begin
                bypass_pending <= 1'b0;
            end else if (bypass_pending) begin
                bypass_cnt <= bypass_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            write_pointer <= cmd_ecc_pkg::PTR_RESET;
            read_pointer <= cmd_ecc_pkg::PTR_RESET;
        end else if (clk_en) begin
            if (init_s2) begin
                write_pointer <= cmd_ecc_pkg::PTR_RESET;
                read_pointer <= cmd_ecc_pkg::PTR_RESET;
            end else begin
                if (write_pointer_advance) begin
                    write_pointer <= write_pointer + 2'h1;
                end
                if (read_pointer_advance) begin
                    read_pointer <= read_pointer + 2'h1;
                end
            end
        end
    end

    // the advance that fills the file is remembered until T3
    logic fill_pending;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fill_pending <= 1'b0;
            file_full_flag <= 1'b0;
        end else if (clk_en) begin
            if (init_s2) begin
                fill_pending <= 1'b0;
                file_full_flag <= 1'b0;
            end else begin
                if (write_pointer_advance && pointer_one_behind) begin
                    fill_pending <= 1'b1;
                end else if (tstate == cmd_ecc_pkg::T3 || read_pointer_advance) begin
                    fill_pending <= 1'b0;
                end
                if (tstate == cmd_ecc_pkg::T3 && fill_pending && !read_pointer_advance) begin
                    file_full_flag <= 1'b1;
                end else if (read_pointer_advance) begin
                    file_full_flag <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // receive latches and check logic
    logic [63:0] data_latch;
    logic [7:0] check_latch;
    logic [7:0] check_sel;
    logic [7:0] check_gen;
    logic single_err;
    logic double_err;
    logic [63:0] flip;
    cmd_ecc_pkg::cycle_state_t state;
    logic full_write;
    logic [63:0] next_data;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_latch <= '0;
            check_latch <= '0;
        end else if (clk_en) begin
            if (array_data_latch_strobe) begin
                data_latch <= array_data_in;
            end else if (state == cmd_ecc_pkg::MERGE ||
                         (state == cmd_ecc_pkg::IDLE && cycle_start && full_write)) begin
                data_latch <= next_data;
            end
            if (check_bit_latch_strobe) begin
                check_latch <= array_check_in;
            end
        end
    end
    assign check_sel = diag_check_select ? diag_check_bits : check_latch;

    secded_code u_code (
        .data(data_latch),
        .check_in(check_sel),
        .check_gen(check_gen),
        .syndrome_bits(syndrome_bits),
        .single_err(single_err),
        .double_err(double_err),
        .flip(flip)
    );
    assign correction_enable = single_err;

    // ==========================================
    // memory cycle sequencer
    logic is_read;
    logic uncorrectable;
    logic [7:0] mask_hold;
    logic [63:0] corrected;
    logic [63:0] byte_en;
    assign full_write = cycle_ext && !cycle_is_read &&
        byte_mask == {cmd_ecc_pkg::FULL_MASK, cmd_ecc_pkg::FULL_MASK};
    assign corrected = data_latch ^ flip;

    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_mask
            assign byte_en[b*8 +: 8] = {8{mask_hold[b]}};
        end
    endgenerate

    always_comb begin
        if (state == cmd_ecc_pkg::IDLE) begin
            next_data = new_data;
        end else begin
            next_data = (new_data & byte_en) | (corrected & ~byte_en);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= cmd_ecc_pkg::IDLE;
            is_read <= 1'b0;
            uncorrectable <= 1'b0;
            mask_hold <= '0;
            array_data_out <= '0;
            array_check_out <= '0;
        end else if (clk_en) begin
            unique case (state)
                cmd_ecc_pkg::IDLE: begin
                    if (cycle_start) begin
                        is_read <= cycle_is_read;
                        mask_hold <= byte_mask;
                        uncorrectable <= 1'b0;
                        state <= full_write ? cmd_ecc_pkg::GEN_WRITE
                                            : cmd_ecc_pkg::CHECK_READ;
                    end
                end
                cmd_ecc_pkg::CHECK_READ: begin
                    if (array_done) begin
                        state <= cmd_ecc_pkg::MERGE;
                    end
                end
                cmd_ecc_pkg::MERGE: begin
                    uncorrectable <= double_err;
                    if (double_err && !is_read) begin
                        array_data_out <= data_latch;
                        array_check_out <= check_latch;
                        state <= cmd_ecc_pkg::ARRAY_WRITE;
                    end else if (is_read) begin
                        array_data_out <= double_err ? data_latch : corrected;
                        array_check_out <= check_gen;
                        state <= single_err ? cmd_ecc_pkg::GEN_WRITE
                                            : cmd_ecc_pkg::IDLE;
                    end else begin
                        state <= cmd_ecc_pkg::GEN_WRITE;
                    end
                end
                cmd_ecc_pkg::GEN_WRITE: begin
                    array_data_out <= data_latch;
                    array_check_out <= check_gen;
                    state <= cmd_ecc_pkg::ARRAY_WRITE;
                end
                cmd_ecc_pkg::ARRAY_WRITE: begin
                    if (array_done) begin
                        state <= cmd_ecc_pkg::IDLE;
                    end
                end
            endcase
        end
    end
    // read rewrite: merge latched the corrected word, reads pass an empty mask

    assign array_read_req = (state == cmd_ecc_pkg::CHECK_READ);
    assign array_write_req = (state == cmd_ecc_pkg::ARRAY_WRITE);
    assign memory_busy_flag = (state != cmd_ecc_pkg::IDLE);

    // ==========================================
    // file bus return path
    logic [1:0] tag_hold;
    logic [1:0] parity_hold;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tag_hold <= cmd_ecc_pkg::TAG_GOOD;
            parity_hold <= 2'h0;
        end else if (clk_en && state == cmd_ecc_pkg::MERGE && is_read) begin
            tag_hold <= double_err ? cmd_ecc_pkg::TAG_SUBSTITUTE :
                        single_err ? cmd_ecc_pkg::TAG_CORRECTED :
                                     cmd_ecc_pkg::TAG_GOOD;
            parity_hold <= double_err ? {^data_latch[63:32], ^data_latch[31:0]} :
                           {^corrected[63:32], ^corrected[31:0]};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            file_data_out <= '0;
            file_parity <= 1'b0;
            read_tag <= cmd_ecc_pkg::TAG_GOOD;
            file_data_valid <= 1'b0;
        end else if (clk_en) begin
            file_data_valid <= !read_mux_enable_n;
            if (!read_mux_enable_n) begin
                file_data_out <= low_half_select_n ? array_data_out[63:32]
                                                   : array_data_out[31:0];
                file_parity <= low_half_select_n ? parity_hold[1] : parity_hold[0];
                read_tag <= tag_hold;
            end
        end
    end

    // ==========================================
    // checks
    sequence advance_at_t0_s;
        tstate == cmd_ecc_pkg::T0 && write_pointer_advance;
    endsequence

    write_adv_a: assert property (@(posedge clk) disable iff (!nrst)
        advance_at_t0_s |=> write_pointer == $past(write_pointer) + 2'h1 || $past(init_s2))
        else $error("write pointer did not advance");
    full_block_a: assert property (@(posedge clk) disable iff (!nrst)
        file_full_flag |-> !write_pointer_advance)
        else $error("write advance while full");
    read_t1_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_en && tstate == cmd_ecc_pkg::T1 && file_not_empty && !memory_busy_flag
        && !init_s2 |-> read_pointer_advance)
        else $error("read pointer missed T1 advance");
    init_clr_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_en && init_s2 |=> write_pointer == 2'h0 && read_pointer == 2'h0)
        else $error("init did not clear pointers");
    room_full_a: assert property (@(posedge clk) disable iff (!nrst)
        file_full_flag && entries_needed != 3'h0 |-> !room_available && !busy_confirm == !valid_format_decoded)
        else $error("room check wrong when full");
    full_skip_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_en && state == cmd_ecc_pkg::IDLE && cycle_start && full_write
        |=> !array_read_req ##0 state == cmd_ecc_pkg::GEN_WRITE)
        else $error("full write performed check read");
    busy_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        array_write_req && !array_done |=> memory_busy_flag)
        else $error("busy dropped before write done");
    uncor_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_en && state == cmd_ecc_pkg::MERGE && double_err && !is_read
        |=> array_data_out == $past(data_latch) && array_check_out == $past(check_latch))
        else $error("uncorrectable write altered data");
endmodule

// *** array_model.sv ***
// array board stand-in: one quadword with check bits, answers after a set delay
`timescale 1ns/100ps
module array_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rd,
    input wire logic wr,
    input wire logic [63:0] wdata,
    input wire logic [7:0] wcheck,
    input wire logic [7:0] delay,
    input wire logic [63:0] flip,
    input wire logic corrupt,
    output logic [63:0] rdata,
    output logic [7:0] rcheck,
    output logic done
);
    logic [63:0] mem;
    logic [7:0] cbits;
    logic [7:0] cnt;
    // ====================
    // read drivers
    // undriven bus shows the inverse so stale data never passes as valid
    assign rdata = rd ? mem : ~mem;
    assign rcheck = rd ? cbits : ~cbits;
    // ====================
    // storage and handshake
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem <= 64'h0;
            cbits <= 8'h00;
            cnt <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            // stored upset, so only a real rewrite can heal it
            if (corrupt)
                mem <= mem ^ flip;
            if ((rd || wr) && !done) begin
                if (cnt >= delay) begin
                    done <= 1'b1;
                    cnt <= 8'h00;
                    if (wr) begin
                        mem <= wdata;
                        cbits <= wcheck;
                    end
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end else begin
                cnt <= 8'h00;
            end
        end
    end
endmodule

// *** testbench.sv ***
// self-checking bench for the command file pointers and the ecc data path
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic init_n = 1'b1;
    logic valid = 1'b0;
    logic [2:0] need = 3'h1;
    logic cs = 1'b0, crd = 1'b0, cext = 1'b0, dsel = 1'b0, corrupt = 1'b0;
    logic rme_n = 1'b1, lhs_n = 1'b1;
    logic [7:0] bm = 8'h00, dchk = 8'h00, dly = 8'h02;
    logic [63:0] nd = 64'h0, flip = 64'h0;
    logic [31:0] seed = 32'h0000EC0F;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    logic room, bconf, full, nempty, rpa, wpa, ard, awr, busy, fdv, fpar, cen, adone, p0, p1;
    logic [1:0] wp, rp, tag;
    logic [7:0] ack, syn, aci;
    logic [63:0] ado, adi, d0;
    logic [31:0] fdo;

    command_file_ecc_datapath command_file_ecc_datapath_i (
        .clk(clk), .nrst(nrst), .clk_en(1'b1), .init_clear_n(init_n),
        .valid_format_decoded(valid), .entries_needed(need), .room_available(room),
        .busy_confirm(bconf), .write_pointer(wp), .read_pointer(rp), .file_full_flag(full),
        .file_not_empty(nempty), .read_pointer_advance(rpa), .write_pointer_advance(wpa),
        .cycle_start(cs), .cycle_is_read(crd), .cycle_ext(cext), .byte_mask(bm),
        .new_data(nd), .read_mux_enable_n(rme_n), .low_half_select_n(lhs_n),
        .diag_check_select(dsel), .diag_check_bits(dchk),
        .array_data_latch_strobe(adone & ard), .check_bit_latch_strobe(adone & ard),
        .array_data_in(adi), .array_check_in(aci), .array_done(adone),
        .array_read_req(ard), .array_write_req(awr), .array_data_out(ado),
        .array_check_out(ack), .memory_busy_flag(busy), .file_data_out(fdo),
        .file_data_valid(fdv), .file_parity(fpar), .read_tag(tag), .syndrome_bits(syn),
        .correction_enable(cen));
    array_model array_model_i (.clk(clk), .nrst(nrst), .rd(ard), .wr(awr), .wdata(ado),
        .wcheck(ack), .delay(dly), .flip(flip), .corrupt(corrupt), .rdata(adi),
        .rcheck(aci), .done(adone));

    // ====================
    // clock and watchdog
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ====================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_room(logic [1:0] w, logic [1:0] r, logic f, logic [2:0] n);
        logic [2:0] free;
        free = 3'h4 - {1'b0, w - r};
        return !f && (free >= n);
    endfunction
    function automatic logic [63:0] merge(logic [63:0] o, logic [63:0] w, logic [7:0] m);
        logic [63:0] r;
        for (int i = 0; i < 8; i++)
            r[i*8 +: 8] = m[i] ? w[i*8 +: 8] : o[i*8 +: 8];
        return r;
    endfunction
    task automatic chk(string what, logic [63:0] e, logic [63:0] g);
        compares++;
        if (e !== g) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic launch(logic r, logic e, logic [7:0] m, logic [63:0] d);
        @(posedge clk);
        cs <= 1'b1;
        crd <= r;
        cext <= e;
        bm <= m;
        nd <= d;
        @(posedge clk);
        cs <= 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy === 1'b1 && n < 200);
        chk("memory_busy_flag", 1'b0, busy);
    endtask
    task automatic half(logic lo, logic [31:0] e, logic [1:0] et, logic dc);
        @(posedge clk);
        rme_n <= 1'b0;
        lhs_n <= !lo;
        @(posedge clk);
        rme_n <= 1'b1;
        @(negedge clk);
        if (dc)
            chk("file_data_out", e, fdo);
        chk("read_tag", et, tag);
        chk("file_data_valid", 1'b1, fdv);
        if (lo)
            p0 = fpar;
        else
            p1 = fpar;
    endtask
    task automatic rdq(logic [63:0] e, logic [1:0] et, logic dc);
        launch(1'b1, 1'b0, 8'h00, 64'h0);
        idle();
        half(1'b1, e[31:0], et, dc);
        half(1'b0, e[63:32], et, dc);
        if (dc)
            chk("file_parity_pair", (^e[31:0]) ^ (^e[63:32]), p0 ^ p1);
    endtask
    task automatic hit(logic [63:0] f);
        @(posedge clk);
        flip <= f;
        corrupt <= 1'b1;
        @(posedge clk);
        corrupt <= 1'b0;
    endtask
    // ====================
    // main sequence
    initial begin
        int n;
        logic [5:0] b;
        logic [7:0] m;
        logic [63:0] nv;
        logic [63:0] f2;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("write_pointer", 2'h0, wp);
        chk("read_pointer", 2'h0, rp);
        // slow full write keeps memory busy so the file fills
        d0 = {xs(), xs()};
        dly <= 8'h28;
        launch(1'b0, 1'b1, 8'hFF, d0);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            valid <= 1'b1;
            need <= (i < 8) ? 3'(xs() % 5) : 3'h1;
            @(negedge clk);
            chk("room_available", exp_room(wp, rp, full, need), room);
            chk("busy_confirm", !exp_room(wp, rp, full, need), bconf);
        end
        chk("memory_busy_flag", 1'b1, busy);
        chk("file_full_flag", 1'b1, full);
        chk("write_pointer", 2'h0, wp);
        chk("read_pointer", 2'h0, rp);
        @(posedge clk);
        valid <= 1'b0;
        idle();
        n = 0;
        while (rpa !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk("file_full_flag", 1'b0, full);
        repeat (16) @(negedge clk);
        chk("read_pointer", 2'h0, rp);
        chk("file_not_empty", 1'b0, nempty);
        // ====================
        // bypass into an empty file, then init
        @(posedge clk);
        valid <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wpa !== 1'b1 && n < 8);
        @(posedge clk);
        valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk("write_pointer", 2'h1, wp);
        chk("read_pointer", 2'h1, rp);
        @(posedge clk);
        init_n <= 1'b0;
        repeat (4) @(posedge clk);
        init_n <= 1'b1;
        @(negedge clk);
        chk("write_pointer", 2'h0, wp);
        chk("read_pointer", 2'h0, rp);
        // ====================
        // ecc reads: clean, single upset, double upset
        dly <= 8'h02;
        rdq(d0, cmd_ecc_pkg::TAG_GOOD, 1'b1);
        chk("syndrome_bits", 8'h00, syn);
        b = 6'(xs());
        hit(64'h1 << b);
        rdq(d0, cmd_ecc_pkg::TAG_CORRECTED, 1'b1);
        rdq(d0, cmd_ecc_pkg::TAG_GOOD, 1'b1);
        f2 = 64'h3 << {b[5:1], 1'b0};
        hit(f2);
        rdq(d0, cmd_ecc_pkg::TAG_SUBSTITUTE, 1'b0);
        chk("correction_enable", 1'b0, cen);
        chk("syndrome_nonzero", 1'b1, syn != 8'h00);
        launch(1'b0, 1'b0, 8'h0F, ~d0);
        idle();
        chk("array_word", d0 ^ f2, array_model_i.mem);
        launch(1'b0, 1'b1, 8'hFF, d0);
        idle();
        rdq(d0, cmd_ecc_pkg::TAG_GOOD, 1'b1);
        // ====================
        // random partial writes merge bytes
        for (int i = 0; i < 4; i++) begin
            m = {1'b0, 6'(xs()), 1'b1};
            nv = {xs(), xs()};
            launch(1'b0, i[0], m, nv);
            idle();
            d0 = merge(d0, nv, m);
            chk("array_word", d0, array_model_i.mem);
            rdq(d0, cmd_ecc_pkg::TAG_GOOD, 1'b1);
        end
        // ====================
        // diagnostic check bits replace the latched ones
        @(posedge clk);
        dsel <= 1'b1;
        dchk <= array_model_i.cbits;
        rdq(d0, cmd_ecc_pkg::TAG_GOOD, 1'b1);
        @(posedge clk);
        dchk <= array_model_i.cbits ^ 8'h03;
        rdq(d0, cmd_ecc_pkg::TAG_SUBSTITUTE, 1'b0);
        @(posedge clk);
        dsel <= 1'b0;
        end_of_test();
    end
endmodule
